// ### lcd_display_memory_scan.sv
// What this block does
// - pointer is a 6-bit up/down counter plus a one-bit bank flag
// - load-pointer command sets bank flag and counter together
// - bank flag 0 picks bank 0, 1 picks bank 1
// - counter addresses words 00h to 31h inside the bank
// - read, write, AND and OR bytes step counter by mode's choice
// - bit set and bit clear step counter per their own option
// - character mode steps counter by five per byte or cursor command
// - counter wraps freely as six bits, no clamping
// - addresses 32h to 3fh leave the memory untouched
// - memory is two banks of fifty 8-bit words
// - written byte is combined per data mode before storing
// - bit commands change single bits of the addressed word
// - memory data reaches the cpu only in read mode
// - scan reads memory per row independently of cpu access
// - eight-row mode scans only the bank chosen by display mode
// - stored one lights the dot, zero leaves it dark
// - sixteen-row single chip shows both banks as 42 by 16
// - sixteen-row multi-chip shows 50 by 16, chip drives one half
// - row and frame timing come from clock, frame rate, mux ratio
// - sync output pulses once per frame, sync input realigns frame
// - codes 000-011: eight rows, dual pins rows 0-7, shared columns
// - 100/101 rows 8-15, 110 rows 0-7, 111 shared pins rows 15-8
`default_nettype none
module lcd_display_memory_scan
  import lcd_scan_pkg::*;
#(
  parameter int unsigned LINE_CYCLES = LINE_CYCLES_DEF
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // register port
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // panel drive
  output logic [MAIN_COLS-1:0] column_outputs_o,
  output logic [7:0] row_outputs_o,
  output logic [7:0] shared_pins_o,
  output logic drive_phase_o,
  // frame sync pin
  input wire logic sync_i,
  output logic sync_o,
  output logic sync_oe_n_o
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0] mem_q [MEM_WORDS];
  logic bank_select_flag_q, bank_select_flag_d;
  logic [5:0] pointer_counter_bits_q, pointer_counter_bits_d;
  logic [2:0] dmode_q, dmode_d;
  logic [1:0] step_q, step_d;
  logic [7:0] disp_q, disp_d;
  logic [1:0] frame_q, frame_d;
  logic [7:0] rdata_q, rdata_d;
  logic mem_we;
  logic [6:0] mem_wa;
  logic [7:0] mem_wd;
  logic [6:0] ptr_idx;
  logic ptr_valid;
  logic [7:0] cur_word;
  logic [2:0] multiplex_mode_code;
  logic mux16;
  logic [3:0] row_q, row_d;

  assign multiplex_mode_code = disp_q[2:0];
  assign mux16 = multiplex_mode_code[2];
  assign ptr_valid = pointer_counter_bits_q <= LAST_WORD;
  assign ptr_idx = bank_select_flag_q ? BANK1_BASE + {1'b0, pointer_counter_bits_q}
                                      : {1'b0, pointer_counter_bits_q};
  assign cur_word = ptr_valid ? mem_q[ptr_idx] : 8'h00;

  // plain 6-bit arithmetic, so 00h-1 gives 3fh and 31h+1 gives 32h
  function automatic logic [5:0] step_ptr(input logic [5:0] cnt, input logic [1:0] sel);
    logic [5:0] res;
    res = cnt;
    case (sel)
      STEP_INC: res = cnt + 6'h01;
      STEP_DEC: res = cnt - 6'h01;
      default: res = cnt;
    endcase
    return res;
  endfunction

  // ---------------------------------------------------------------
  // cpu access path
  // ---------------------------------------------------------------
  always_comb begin
    bank_select_flag_d = bank_select_flag_q;
    pointer_counter_bits_d = pointer_counter_bits_q;
    dmode_d = dmode_q;
    step_d = step_q;
    disp_d = disp_q;
    frame_d = frame_q;
    rdata_d = 8'h00;
    mem_we = 1'b0;
    mem_wa = ptr_idx;
    mem_wd = cur_word;
    if (wr_i) begin
      case (addr_i)
        ADDR_PTR: begin
          bank_select_flag_d = wdata_i[PTR_BANK_BIT];
          pointer_counter_bits_d = wdata_i[5:0];
        end
        ADDR_DMODE: begin
          dmode_d = wdata_i[2:0];
          step_d = wdata_i[STEP_LSB+:2];
        end
        ADDR_DATA: begin
          // the character pattern is stored by the generator outside
          case (dmode_q)
            DM_WRITE: mem_wd = wdata_i;
            DM_AND: mem_wd = cur_word & wdata_i;
            DM_OR: mem_wd = cur_word | wdata_i;
            default: mem_wd = cur_word;
          endcase
          mem_we = ptr_valid && (dmode_q == DM_WRITE || dmode_q == DM_AND
                                 || dmode_q == DM_OR);
          if (dmode_q == DM_CHAR) begin
            pointer_counter_bits_d = (step_q == STEP_DEC) ? pointer_counter_bits_q - CHAR_STEP
                                                          : pointer_counter_bits_q + CHAR_STEP;
          end else if (dmode_q != DM_READ) begin
            pointer_counter_bits_d = step_ptr(pointer_counter_bits_q, step_q);
          end
        end
        ADDR_BITOP: begin
          mem_wd = wdata_i[BITOP_SET_BIT] ? cur_word | (8'h01 << wdata_i[2:0])
                                          : cur_word & ~(8'h01 << wdata_i[2:0]);
          mem_we = ptr_valid;
          pointer_counter_bits_d = step_ptr(pointer_counter_bits_q, wdata_i[BITOP_STEP_LSB+:2]);
        end
        ADDR_CURSOR: begin
          // cursor lives in bit 7, which the character patterns never use
          if (dmode_q == DM_CHAR) begin
            mem_wd = {wdata_i[0], cur_word[6:0]};
            mem_we = ptr_valid;
            pointer_counter_bits_d = (step_q == STEP_DEC) ? pointer_counter_bits_q - CHAR_STEP
                                                          : pointer_counter_bits_q + CHAR_STEP;
          end
        end
        ADDR_DISP: disp_d = wdata_i;
        ADDR_FRAME: frame_d = wdata_i[1:0];
        default: ;
      endcase
    end else if (rd_i) begin
      case (addr_i)
        ADDR_PTR: rdata_d = {bank_select_flag_q, 1'b0, pointer_counter_bits_q};
        ADDR_DMODE: rdata_d = {3'h0, step_q, dmode_q};
        ADDR_DATA: begin
          if (dmode_q == DM_READ) begin
            rdata_d = cur_word;
            pointer_counter_bits_d = step_ptr(pointer_counter_bits_q, step_q);
          end
        end
        ADDR_DISP: rdata_d = disp_q;
        ADDR_FRAME: rdata_d = {6'h00, frame_q};
        ADDR_STATUS: rdata_d = {drive_phase_o, 3'h0, row_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bank_select_flag_q <= 1'b0;
      pointer_counter_bits_q <= 6'h00;
      dmode_q <= DMODE_RST;
      step_q <= STEP_RST;
      disp_q <= DISP_RST;
      frame_q <= FRAME_RST;
      rdata_q <= 8'h00;
    end else begin
      bank_select_flag_q <= bank_select_flag_d;
      pointer_counter_bits_q <= pointer_counter_bits_d;
      dmode_q <= dmode_d;
      step_q <= step_d;
      disp_q <= disp_d;
      frame_q <= frame_d;
      rdata_q <= rdata_d;
    end
  end

  // display memory has no reset; software clears it
  always_ff @(posedge clk_i) begin
    if (mem_we) begin
      mem_q[mem_wa] <= mem_wd;
    end
  end

  assign rdata_o = rdata_q;

  // ---------------------------------------------------------------
  // frame timing and sync
  // ---------------------------------------------------------------
  logic [16:0] timer_q, timer_d;
  logic phase_q, phase_d;
  logic sync_out_q, sync_out_d;
  logic sync_meta_q, sync_sync_q, sync_prev_q;
  logic [16:0] row_len;
  logic sync_master;
  logic sync_edge;
  logic frame_start;

  assign sync_master = disp_q[DISP_SYNC_OUT_BIT];
  // faster frame codes shorten the row; sixteen rows halve it again
  assign row_len = 17'(LINE_CYCLES >> ({30'h0, frame_q} + {31'h0, mux16}));
  assign sync_edge = !sync_master && sync_sync_q && !sync_prev_q;

  always_comb begin
    row_d = row_q;
    timer_d = timer_q - 17'h00001;
    frame_start = 1'b0;
    if (sync_edge) begin
      row_d = 4'h0;
      timer_d = row_len - 17'h00001;
      frame_start = 1'b1;
    end else if (timer_q == 17'h00000) begin
      timer_d = row_len - 17'h00001;
      if (row_q == {mux16, 3'h7}) begin
        row_d = 4'h0;
        frame_start = sync_master;
      end else begin
        row_d = row_q + 4'h1;
      end
    end
    // leaving sixteen-row mode mid-frame must not strand the counter in rows 8-15
    if (!mux16) begin
      row_d[3] = 1'b0;
    end
    phase_d = frame_start ? !phase_q : phase_q;
    sync_out_d = frame_start && sync_master;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      row_q <= 4'h0;
      timer_q <= 17'h00000;
      phase_q <= 1'b0;
      sync_out_q <= 1'b0;
      sync_meta_q <= 1'b0;
      sync_sync_q <= 1'b0;
      sync_prev_q <= 1'b0;
    end else begin
      row_q <= row_d;
      timer_q <= timer_d;
      phase_q <= phase_d;
      sync_out_q <= sync_out_d;
      sync_meta_q <= sync_i;
      sync_sync_q <= sync_meta_q;
      sync_prev_q <= sync_sync_q;
    end
  end

  assign sync_o = sync_out_q;
  assign sync_oe_n_o = !sync_master;
  assign drive_phase_o = phase_q;

  // ---------------------------------------------------------------
  // scan and pin assignment
  // ---------------------------------------------------------------
  logic [NUM_COLS-1:0] col_d;
  logic [15:0] row_sel;
  logic scan_bank;
  logic [MAIN_COLS-1:0] col_q;
  logic [7:0] dual_q, dual_d;
  logic [7:0] shared_q, shared_d;

  // eight rows use the chosen bank; sixteen rows stack bank 1 under bank 0
  assign scan_bank = mux16 ? row_q[3] : disp_q[DISP_BANK_BIT];
  assign row_sel = 16'h0001 << row_q;

  for (genvar m = 0; m < NUM_COLS; m++) begin : g_col
    // a stored one selects the column, lighting the dot
    assign col_d[m] = mem_q[scan_bank ? BANK_WORDS + m : m][row_q[2:0]];
  end

  always_comb begin
    dual_d = row_sel[7:0];
    shared_d = col_d[NUM_COLS-1:MAIN_COLS];
    if (multiplex_mode_code == MUX_16_HIGH0 || multiplex_mode_code == MUX_16_HIGH1) begin
      dual_d = row_sel[15:8];
    end
    if (multiplex_mode_code == MUX_16_SINGLE) begin
      for (int k = 0; k < 8; k++) begin
        shared_d[k] = row_sel[15-k];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      col_q <= '0;
      dual_q <= 8'h00;
      shared_q <= 8'h00;
    end else begin
      col_q <= col_d[MAIN_COLS-1:0];
      dual_q <= dual_d;
      shared_q <= shared_d;
    end
  end

  assign column_outputs_o = col_q;
  assign row_outputs_o = dual_q;
  assign shared_pins_o = shared_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_ptr_load;
    wr_i && addr_i == ADDR_PTR;
  endsequence

  sequence s_write_inc;
    wr_i && addr_i == ADDR_DATA && dmode_q == DM_WRITE && step_q == STEP_INC;
  endsequence

  chk_ptr_load: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_ptr_load |=> pointer_counter_bits_q == $past(wdata_i[5:0])
                   && bank_select_flag_q == $past(wdata_i[7]))
    else $error("pointer load lost");

  chk_write_step: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_write_inc |=> pointer_counter_bits_q == $past(pointer_counter_bits_q) + 6'h01)
    else $error("write did not advance pointer");

  chk_char_step: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wr_i && addr_i == ADDR_DATA && dmode_q == DM_CHAR && step_q == STEP_DEC
    |=> pointer_counter_bits_q == $past(pointer_counter_bits_q) - 6'h05)
    else $error("character step not five");

  chk_oob_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
    pointer_counter_bits_q > LAST_WORD |-> !mem_we)
    else $error("write outside bank");

  chk_read_gate: assert property (@(posedge clk_i) disable iff (!rstn_i)
    rd_i && addr_i == ADDR_DATA && dmode_q != DM_READ |=> rdata_o == 8'h00)
    else $error("memory read outside read mode");

  chk_sync_pulse: assert property (@(posedge clk_i) disable iff (!rstn_i)
    sync_out_q |-> $past(sync_master) ##1 !sync_out_q)
    else $error("sync pulse too long");

  chk_phase_flip: assert property (@(posedge clk_i) disable iff (!rstn_i)
    frame_start |=> phase_q != $past(phase_q) && row_q == 4'h0)
    else $error("phase did not flip at frame");

  chk_single_rows: assert property (@(posedge clk_i) disable iff (!rstn_i)
    multiplex_mode_code == MUX_16_SINGLE && row_q == 4'h8 ##1 row_q == 4'h8
    |-> shared_pins_o == 8'h80)
    else $error("shared pins not rows 15-8");

  chk_rows_8: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !mux16 |=> row_q < 4'h8)
    else $error("eight-row scan left range");

  chk_read_step: assert property (@(posedge clk_i) disable iff (!rstn_i)
    rd_i && !wr_i && addr_i == ADDR_DATA && dmode_q == DM_READ && step_q == STEP_INC
    |=> pointer_counter_bits_q == $past(pointer_counter_bits_q) + 6'h01)
    else $error("read did not advance pointer");

  chk_dual_onehot: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !mux16 ##1 !mux16 |=> $onehot(row_outputs_o))
    else $error("eight-row drive not one-hot");

endmodule
`default_nettype wire

// ### lcd_scan_pkg.sv
`default_nettype none
package lcd_scan_pkg;
  // ---------------------------------------------------------------
  // register map (plain port, 3-bit address)
  // ---------------------------------------------------------------
  localparam logic [2:0] ADDR_PTR = 3'h0;
  localparam logic [2:0] ADDR_DMODE = 3'h1;
  localparam logic [2:0] ADDR_DATA = 3'h2;
  localparam logic [2:0] ADDR_BITOP = 3'h3;
  localparam logic [2:0] ADDR_CURSOR = 3'h4;
  localparam logic [2:0] ADDR_DISP = 3'h5;
  localparam logic [2:0] ADDR_FRAME = 3'h6;
  localparam logic [2:0] ADDR_STATUS = 3'h7;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int PTR_BANK_BIT = 7;
  localparam int STEP_LSB = 3;
  localparam int BITOP_SET_BIT = 3;
  localparam int BITOP_STEP_LSB = 4;
  localparam int DISP_BANK_BIT = 3;
  localparam int DISP_SYNC_OUT_BIT = 4;

  // data processing modes
  localparam logic [2:0] DM_WRITE = 3'h0;
  localparam logic [2:0] DM_READ = 3'h1;
  localparam logic [2:0] DM_AND = 3'h2;
  localparam logic [2:0] DM_OR = 3'h3;
  localparam logic [2:0] DM_CHAR = 3'h4;

  // pointer step selections
  localparam logic [1:0] STEP_HOLD = 2'h0;
  localparam logic [1:0] STEP_INC = 2'h1;
  localparam logic [1:0] STEP_DEC = 2'h2;
  localparam logic [5:0] CHAR_STEP = 6'h05;

  // multiplex mode codes
  localparam logic [2:0] MUX_16_HIGH0 = 3'h4;
  localparam logic [2:0] MUX_16_HIGH1 = 3'h5;
  localparam logic [2:0] MUX_16_SINGLE = 3'h7;

  // ---------------------------------------------------------------
  // memory geometry
  // ---------------------------------------------------------------
  localparam int BANK_WORDS = 50;
  localparam int MEM_WORDS = 2 * BANK_WORDS;
  localparam logic [5:0] LAST_WORD = 6'h31;
  localparam logic [6:0] BANK1_BASE = 7'h32;
  localparam int NUM_COLS = 50;
  localparam int MAIN_COLS = 42;

  // ---------------------------------------------------------------
  // reset values and timing
  // ---------------------------------------------------------------
  localparam logic [2:0] DMODE_RST = DM_WRITE;
  localparam logic [1:0] STEP_RST = STEP_INC;
  localparam logic [7:0] DISP_RST = 8'h00;
  localparam logic [1:0] FRAME_RST = 2'h0;
  localparam int CLK_HZ = 50_000_000;
  localparam int FRAME_PERIOD_US = 12_500;
  localparam int LINE_CYCLES_DEF = (CLK_HZ / 1_000_000) * FRAME_PERIOD_US / 8;
endpackage
`default_nettype wire

// ### lcd_sync_peer_model.sv
`default_nettype none
module lcd_sync_peer_model #(
  parameter int PERIOD = 100
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // sync pin drive, pin is pulled down while released
  input wire logic en_i,
  output logic sync_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // sync master peer
  // ---------------------------------------------------------------
  int cnt_q;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q <= 0;
      sync_o <= 1'b0;
    end else begin
      cnt_q <= (cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
      sync_o <= en_i && (cnt_q == PERIOD - 1);
    end
  end
endmodule
`default_nettype wire

// ### tb.sv
`default_nettype none
module tb
  import lcd_scan_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // harness
  // ---------------------------------------------------------------
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic peer_en = 1'b0;
  logic peer_sync;
  logic [7:0] rdata_o;
  logic [MAIN_COLS-1:0] column_outputs_o;
  logic [7:0] row_outputs_o;
  logic [7:0] shared_pins_o;
  logic drive_phase_o;
  logic sync_o;
  logic sync_oe_n_o;
  wire logic sync_pin;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;

  always #10 clk_i = ~clk_i;
  // released pin falls to the pull-down level
  assign sync_pin = !sync_oe_n_o ? sync_o : peer_sync;

  lcd_display_memory_scan #(.LINE_CYCLES(8)) lcd_display_memory_scan_inst (
    .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .column_outputs_o(column_outputs_o), .row_outputs_o(row_outputs_o),
    .shared_pins_o(shared_pins_o), .drive_phase_o(drive_phase_o), .sync_i(sync_pin), .sync_o(sync_o),
    .sync_oe_n_o(sync_oe_n_o));

  lcd_sync_peer_model #(.PERIOD(100)) lcd_sync_peer_model_inst (
    .clk_i(clk_i), .rstn_i(rstn_i), .en_i(peer_en), .sync_o(peer_sync));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ceiling well above the fewer than two thousand cycles the tests need
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("Error at %0t: run hung", $time);
      give_verdict();
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rdv(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 check(rdata_o, e);
  endtask

  function automatic logic [7:0] dm(input logic [2:0] mode, input logic [1:0] step);
    return {3'h0, step, mode};
  endfunction

  function automatic logic [7:0] pat(input logic b, input int m);
    return 8'(m * 37 + (b ? 91 : 0)) ^ 8'h5a;
  endfunction

  task automatic chk_cols(input int r, input logic b, input logic sh);
    logic [MAIN_COLS-1:0] e;
    logic [7:0] es;
    logic [7:0] w;
    for (int m = 0; m < MAIN_COLS; m++) begin
      w = pat(b, m);
      e[m] = w[r % 8];
    end
    for (int k = 0; k < 8; k++) begin
      w = pat(b, MAIN_COLS + k);
      es[k] = w[r % 8];
    end
    check(column_outputs_o, e);
    if (sh) check(shared_pins_o, es);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_cpu();
    rdv(ADDR_PTR, 8'h00);
    check(sync_oe_n_o, 1'b1);
    wr(ADDR_PTR, 8'h81);
    wr(ADDR_DATA, 8'h55);
    rdv(ADDR_PTR, 8'h82);
    @(posedge clk_i);
    #1 check(rdata_o, 8'h00);
    wr(ADDR_PTR, 8'h01);
    rdv(ADDR_DATA, 8'h00);
    rdv(ADDR_PTR, 8'h01);
    wr(ADDR_DATA, 8'haa);
    wr(ADDR_DMODE, dm(DM_READ, STEP_INC));
    wr(ADDR_PTR, 8'h81);
    rdv(ADDR_DATA, 8'h55);
    wr(ADDR_PTR, 8'h01);
    rdv(ADDR_DATA, 8'haa);
    rdv(ADDR_PTR, 8'h02);
    $display("test cpu access done");
  endtask

  task automatic t_wrap();
    wr(ADDR_DMODE, dm(DM_WRITE, STEP_DEC));
    wr(ADDR_PTR, 8'h00);
    wr(ADDR_DATA, 8'h00);
    rdv(ADDR_PTR, 8'h3f);
    wr(ADDR_DMODE, dm(DM_WRITE, STEP_INC));
    wr(ADDR_PTR, 8'h80);
    wr(ADDR_DATA, 8'ha5);
    wr(ADDR_PTR, 8'h31);
    wr(ADDR_DATA, 8'h3c);
    rdv(ADDR_PTR, 8'h32);
    wr(ADDR_DATA, 8'h00);
    rdv(ADDR_PTR, 8'h33);
    wr(ADDR_DMODE, dm(DM_READ, STEP_HOLD));
    wr(ADDR_PTR, 8'h80);
    rdv(ADDR_DATA, 8'ha5);
    wr(ADDR_PTR, 8'h31);
    rdv(ADDR_DATA, 8'h3c);
    wr(ADDR_PTR, 8'h32);
    rdv(ADDR_DATA, 8'h00);
    $display("test pointer wrap done");
  endtask

  task automatic t_modify();
    wr(ADDR_DMODE, dm(DM_WRITE, STEP_HOLD));
    wr(ADDR_PTR, 8'h02);
    wr(ADDR_DATA, 8'hf0);
    wr(ADDR_DMODE, dm(DM_AND, STEP_HOLD));
    wr(ADDR_DATA, 8'h3c);
    rdv(ADDR_PTR, 8'h02);
    wr(ADDR_DMODE, dm(DM_OR, STEP_DEC));
    wr(ADDR_DATA, 8'h05);
    rdv(ADDR_PTR, 8'h01);
    wr(ADDR_DMODE, dm(DM_WRITE, STEP_HOLD));
    wr(ADDR_PTR, 8'h02);
    wr(ADDR_BITOP, 8'h09);
    rdv(ADDR_PTR, 8'h02);
    wr(ADDR_BITOP, 8'h25);
    rdv(ADDR_PTR, 8'h01);
    wr(ADDR_DMODE, dm(DM_READ, STEP_HOLD));
    wr(ADDR_PTR, 8'h02);
    rdv(ADDR_DATA, 8'h17);
    wr(ADDR_DMODE, dm(DM_WRITE, STEP_HOLD));
    wr(ADDR_PTR, 8'h0f);
    wr(ADDR_DATA, 8'h2a);
    wr(ADDR_DMODE, dm(DM_CHAR, STEP_INC));
    wr(ADDR_PTR, 8'h0a);
    wr(ADDR_DATA, 8'h41);
    rdv(ADDR_PTR, 8'h0f);
    wr(ADDR_DMODE, dm(DM_CHAR, STEP_DEC));
    wr(ADDR_CURSOR, 8'h01);
    rdv(ADDR_PTR, 8'h0a);
    wr(ADDR_DMODE, dm(DM_READ, STEP_HOLD));
    wr(ADDR_PTR, 8'h0f);
    rdv(ADDR_DATA, 8'haa);
    $display("test data modes done");
  endtask

  task automatic t_scan(input logic [2:0] code, input logic [1:0] fr, input logic bank);
    int sp;
    int tg;
    int hits;
    int per;
    int r;
    logic ph;
    logic half;
    sp = 0;
    tg = 0;
    hits = 0;
    half = (code == MUX_16_HIGH0 || code == MUX_16_HIGH1 || code == 3'h6);
    per = (8 >> (fr + code[2])) * (code[2] ? 16 : 8);
    wr(ADDR_FRAME, {6'h00, fr});
    wr(ADDR_DISP, {3'h0, 1'b1, bank, code});
    repeat (70) @(posedge clk_i);
    #1 ph = drive_phase_o;
    repeat (128) begin
      @(posedge clk_i);
      #1;
      if (sync_o === 1'b1) sp++;
      if (drive_phase_o !== ph) tg++;
      ph = drive_phase_o;
      for (int j = 0; j < 8; j++) begin
        r = -1;
        if (row_outputs_o[j] === 1'b1) r = (code == MUX_16_HIGH0 || code == MUX_16_HIGH1) ? j + 8 : j;
        if (code == MUX_16_SINGLE && shared_pins_o[j] === 1'b1) r = 15 - j;
        if (r >= 0) begin
          hits++;
          chk_cols(r, code[2] ? 1'(r >> 3) : bank, code != MUX_16_SINGLE);
        end
      end
    end
    check(hits, half ? 64 : 128);
    check(sp, 128 / per);
    check(tg, 128 / per);
    check(sync_oe_n_o, 1'b0);
    $display("test scan mode %0d done", code);
  endtask

  task automatic t_sync_in();
    int tg;
    int pk;
    int sp;
    logic ph;
    tg = 0;
    pk = 0;
    sp = 0;
    wr(ADDR_FRAME, 8'h00);
    wr(ADDR_DISP, 8'h00);
    @(posedge clk_i);
    peer_en <= 1'b1;
    for (int i = 0; i < 200 && peer_sync !== 1'b1; i++) begin
      @(posedge clk_i);
      #1;
    end
    repeat (10) @(posedge clk_i);
    #1 ph = drive_phase_o;
    repeat (300) begin
      @(posedge clk_i);
      #1;
      if (peer_sync === 1'b1) pk++;
      if (sync_o === 1'b1) sp++;
      if (drive_phase_o !== ph) tg++;
      ph = drive_phase_o;
    end
    check(pk, 3);
    check(tg, 3);
    check(sp, 0);
    check(sync_oe_n_o, 1'b1);
    $display("test sync input done");
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_cpu();
    t_wrap();
    t_modify();
    wr(ADDR_DMODE, dm(DM_WRITE, STEP_INC));
    for (int b = 0; b < 2; b++) begin
      wr(ADDR_PTR, {1'(b), 7'h00});
      for (int m = 0; m < BANK_WORDS; m++) wr(ADDR_DATA, pat(1'(b), m));
    end
    t_scan(3'h0, 2'h0, 1'b0);
    t_scan(3'h3, 2'h1, 1'b1);
    t_scan(MUX_16_HIGH0, 2'h0, 1'b0);
    t_scan(3'h6, 2'h0, 1'b0);
    t_scan(MUX_16_SINGLE, 2'h0, 1'b0);
    t_sync_in();
    give_verdict();
  end
endmodule
`default_nettype wire
